// File: src/host_control_defines.svh
/*
  Offsets, bit positions and reset values for the host control upper flags.
  Assumes a 32-bit register port with byte offsets as addresses.
*/
`ifndef HOST_CONTROL_DEFINES_SVH
`define HOST_CONTROL_DEFINES_SVH
`define HC_SET_OFFSET        8'h50
`define HC_CLEAR_OFFSET      8'h54
`define HC_BIT_IMAGE_VALID   31
`define HC_BIT_SWAP_DISABLE  30
`define HC_BIT_TARDY_ENABLE  29
`define HC_BIT_CONFIG_OWNER  23
`define HC_BIT_LINK_ON       17
`define HC_OWNER_DEFAULT     1'b1
`define HC_ACK_COMPLETE      4'h1
`define HC_ACK_TARDY         4'hB
`define HC_ACK_TYPE_ERROR    4'hE
`endif

// File: src/host_control_pkg.sv
/*
  Types for the host control upper flags block.
  Assumes nothing beyond the defines header.
*/
package host_control_pkg;
  typedef enum logic [1:0] {
    REQ_ROM_BLOCK_READ = 2'b00,
    REQ_BUS_INFO       = 2'b01,
    REQ_OTHER_ASYNC    = 2'b10,
    REQ_NONE           = 2'b11
  } req_kind_t;
endpackage

// File: src/host_control_upper_flags.sv
/*
  Upper flags of the host control set/clear pair, with ack selection for
  incoming requests and the tardy event pulse.
  Assumes a single-cycle register port, request kinds decoded upstream,
  and the owner strap/EEPROM value valid whenever owner_load is high.
*/
// Notes on behaviour
// - image valid set: config ROM block reads answered, atomic update allowed
// - image valid clear: config ROM block reads get ack_type_error, or ack_tardy when tardy enable is set and the node is busy
// - bus reset with image valid clear leaves ROM mapping/header/options alone
// - image valid sticks until hardware reset, soft reset or fetch error
// - byte swap disable steers swapping for DMA and outside physical accesses
// - tardy enable lets the node answer accesses to itself with ack_tardy
// - sending ack_tardy raises the ack_tardy interrupt event
// - bits 28 to 24 read as zero
// - config owner flag is read-only, loaded from EEPROM, defaults to one
// - writing ones at set address sets flags (image valid only with link off), at clear address clears only swap disable and tardy enable
// - link off: no packets received, processed or transmitted
`include "host_control_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module host_control_upper_flags
  import host_control_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32,
  parameter int ACK_W  = 4
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        soft_reset,
  input  wire logic        reg_write,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic        link_on,
  input  wire logic        owner_load,
  input  wire logic        owner_value,
  input  wire logic        bus_info_fetch_error,
  input  wire logic        bus_reset,
  input  wire logic        req_valid,
  input  wire req_kind_t   req_kind,
  input  wire logic        req_busy,
  output logic             ack_valid,
  output logic      [ACK_W-1:0] ack_code,
  output logic             rom_update_allow,
  output logic             rom_regs_update,
  output logic             byte_swap_on,
  output logic             ack_tardy_event
);

  // flag state: three host flags plus the owner strap
  logic             image_valid_reg, image_valid_next;
  logic             swap_disable_reg, swap_disable_next;
  logic             tardy_enable_reg, tardy_enable_next;
  logic             config_owner_reg, config_owner_next;

  // acknowledge state for the request port
  logic             ack_valid_reg, ack_valid_next;
  logic [ACK_W-1:0] ack_code_reg, ack_code_next;
  logic             tardy_event_reg, tardy_event_next;

  // write decode for the set and clear addresses
  logic             set_hit;
  logic             clr_hit;

  // request accepted this cycle
  logic             req_taken;

  // one address per write, so set and clear never meet in one cycle
  assign set_hit = reg_write && (reg_addr == `HC_SET_OFFSET);
  assign clr_hit = reg_write && (reg_addr == `HC_CLEAR_OFFSET);

  // flag next values from set/clear writes and hardware events
  always_comb begin
    // hold every flag unless a write or an event below moves it
    image_valid_next  = image_valid_reg;
    swap_disable_next = swap_disable_reg;
    tardy_enable_next = tardy_enable_reg;
    config_owner_next = config_owner_reg;

    // image valid: set only while link is off
    // a clear-address write does not drop it, only reset-like events do
    if (set_hit && reg_wdata[`HC_BIT_IMAGE_VALID] && !link_on) begin
      image_valid_next = 1'b1;
    end

    // fetch error or soft reset beats a set in the same cycle
    if (bus_info_fetch_error || soft_reset) begin
      image_valid_next = 1'b0;
    end

    // swap disable: ones set or clear, zeros leave the flag alone
    if (set_hit && reg_wdata[`HC_BIT_SWAP_DISABLE]) begin
      swap_disable_next = 1'b1;
    end else if (clr_hit && reg_wdata[`HC_BIT_SWAP_DISABLE]) begin
      swap_disable_next = 1'b0;
    end

    // tardy enable: same set/clear behaviour as swap disable
    if (set_hit && reg_wdata[`HC_BIT_TARDY_ENABLE]) begin
      tardy_enable_next = 1'b1;
    end else if (clr_hit && reg_wdata[`HC_BIT_TARDY_ENABLE]) begin
      tardy_enable_next = 1'b0;
    end

    // soft reset returns both plain flags to their reset value
    // and wins over a set written in the same cycle
    if (soft_reset) begin
      swap_disable_next = 1'b0;
      tardy_enable_next = 1'b0;
    end

    // owner flag follows only the EEPROM load, never a register write
    if (owner_load) begin
      config_owner_next = owner_value;
    end
  end

  // flag registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      image_valid_reg  <= 1'b0;
      swap_disable_reg <= 1'b0;
      tardy_enable_reg <= 1'b0;
      config_owner_reg <= `HC_OWNER_DEFAULT;
    end else if (clk_en) begin
      image_valid_reg  <= image_valid_next;
      swap_disable_reg <= swap_disable_next;
      tardy_enable_reg <= tardy_enable_next;
      config_owner_reg <= config_owner_next;
    end
  end

  // a request counts only while the link is on and no soft reset runs
  assign req_taken = req_valid && link_on && !soft_reset && (req_kind != REQ_NONE);

  // acknowledge selection for incoming requests
  // priority: tardy, then type error, then complete
  always_comb begin
    // default: no ack this cycle, the code keeps its last value
    ack_valid_next   = 1'b0;
    ack_code_next    = ack_code_reg;
    tardy_event_next = 1'b0;

    if (req_taken) begin
      ack_valid_next = 1'b1;

      // busy node with tardy on answers tardy and raises the event
      if (tardy_enable_reg && req_busy) begin
        ack_code_next    = `HC_ACK_TARDY;
        tardy_event_next = 1'b1;

      // ROM block read before the image is valid is refused
      end else if (req_kind == REQ_ROM_BLOCK_READ && !image_valid_reg) begin
        ack_code_next = `HC_ACK_TYPE_ERROR;

      // everything else completes normally
      end else begin
        ack_code_next = `HC_ACK_COMPLETE;
      end
    end
  end

  // acknowledge registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_valid_reg   <= 1'b0;
      ack_code_reg    <= `HC_ACK_COMPLETE;
      tardy_event_reg <= 1'b0;
    end else if (clk_en) begin
      ack_valid_reg   <= ack_valid_next;
      ack_code_reg    <= ack_code_next;
      tardy_event_reg <= tardy_event_next;
    end
  end

  // outputs from flops (byte swap through an inverter), except the bus reset gate
  // which must follow the bus reset level in the same cycle
  assign ack_valid        = ack_valid_reg;
  assign ack_code         = ack_code_reg;
  assign ack_tardy_event  = tardy_event_reg;
  assign rom_update_allow = image_valid_reg;
  assign rom_regs_update  = bus_reset && image_valid_reg;
  assign byte_swap_on     = !swap_disable_reg;

  // readback at either address; reserved and unowned bits read zero
  // both addresses read back the same flag word
  always_comb begin
    reg_rdata = '0;

    // only the owned flags and the link echo are ever non-zero
    if (reg_addr == `HC_SET_OFFSET || reg_addr == `HC_CLEAR_OFFSET) begin
      reg_rdata[`HC_BIT_IMAGE_VALID]  = image_valid_reg;
      reg_rdata[`HC_BIT_SWAP_DISABLE] = swap_disable_reg;
      reg_rdata[`HC_BIT_TARDY_ENABLE] = tardy_enable_reg;
      reg_rdata[`HC_BIT_CONFIG_OWNER] = config_owner_reg;
      reg_rdata[`HC_BIT_LINK_ON]      = link_on;
    end
  end

endmodule
`default_nettype wire

// File: verification/flags_properties.sv
/* port assertions for the upper flags block
   assumes the design package is compiled first */
`timescale 1ns/100ps
`default_nettype none
module flags_checker
  import host_control_pkg::*;
(
  input wire logic        clk, arst_n, clk_en, soft_reset, reg_write, link_on,
  input wire logic        bus_info_fetch_error, bus_reset, req_valid, req_busy,
  input wire logic        ack_valid, rom_update_allow, rom_regs_update, ack_tardy_event,
  input wire logic        byte_swap_on,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic [3:0]  ack_code,
  input wire req_kind_t   req_kind
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic tk, rom;
  // request taken, and a flag readback that is valid this cycle
  assign tk = req_valid && clk_en && link_on && !soft_reset && req_kind != REQ_NONE;
  assign rom = tk && req_kind == REQ_ROM_BLOCK_READ && reg_addr == 8'h50 && !reg_write;
  a_ack_next: assert property (tk |=> ack_valid) else $error("no ack");
  a_link_off_quiet: assert property (req_valid && clk_en && !link_on |=> !ack_valid)
    else $error("ack while off");
  a_tardy_code: assert property (tk && req_busy && reg_addr == 8'h50 && !reg_write
    && reg_rdata[29] |=> ack_code == 4'hB && ack_tardy_event) else $error("no tardy");
  a_event_pairs: assert property (ack_tardy_event == (ack_valid && ack_code == 4'hB))
    else $error("event mismatch");
  a_rom_refused: assert property (rom && !req_busy && !reg_rdata[31] |=> ack_code == 4'hE)
    else $error("no type error");
  a_rom_served: assert property (rom && !req_busy && reg_rdata[31] |=> ack_code == 4'h1)
    else $error("no complete");
  a_reserved_zero: assert property (reg_rdata[28:24] == 5'h00) else $error("rsvd set");
  a_swap_set: assert property (reg_write && clk_en && !soft_reset && reg_addr == 8'h50
    && reg_wdata[30] |=> !byte_swap_on) else $error("swap not set");
  a_image_sticky: assert property (rom_update_allow && !soft_reset && !bus_info_fetch_error
    |=> rom_update_allow) else $error("image dropped");
  a_rom_regs_gate: assert property (rom_regs_update == (bus_reset && rom_update_allow))
    else $error("rom regs gate");
endmodule
bind host_control_upper_flags flags_checker chk (.clk(clk), .arst_n(arst_n),
  .clk_en(clk_en), .soft_reset(soft_reset), .reg_write(reg_write), .link_on(link_on),
  .bus_info_fetch_error(bus_info_fetch_error), .bus_reset(bus_reset),
  .req_valid(req_valid), .req_busy(req_busy), .ack_valid(ack_valid),
  .rom_update_allow(rom_update_allow), .rom_regs_update(rom_regs_update),
  .ack_tardy_event(ack_tardy_event), .byte_swap_on(byte_swap_on), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ack_code(ack_code), .req_kind(req_kind));
`default_nettype wire

// File: verification/remote_node_model.sv
/* remote node sending one-cycle requests
   assumes start is raised between clock edges */
`timescale 1ns/100ps
`default_nettype none
module remote_node_model
  import host_control_pkg::*;
(
  input  wire logic      clk, start, busy_in,
  input  wire req_kind_t kind_in,
  output req_kind_t      req_kind,
  output logic           req_valid, req_busy
);
  // request lasts one cycle; kind parks at none and busy flips when idle
  always @(posedge clk) begin
    req_valid <= start;
    req_kind <= start ? kind_in : REQ_NONE;
    req_busy <= start ? busy_in : ~busy_in;
  end
endmodule
`default_nettype wire

// File: verification/host_control_upper_flags_tb_top.sv
/* self-checking bench for the upper flags block
   assumes design, checker and remote node model compiled first */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module host_control_upper_flags_tb_top
  import host_control_pkg::*;
;
  logic clk = 0, arst_n = 0, sr = 0, wr_en = 0, lk = 0, st = 0, bz = 0, fe = 0, br = 0;
  logic rv, rb, av, al, ru, so, ev;
  logic ce = 1, ol = 0, ov = 0;
  logic [7:0] ad = 8'h50;
  logic [31:0] wd = 0, rd;
  logic [3:0] cd;
  req_kind_t kd = REQ_NONE, rk;
  int num_errors = 0, checked = 0, cycles = 0;
  always #20 clk = ~clk;
  remote_node_model peer (.clk(clk), .start(st), .busy_in(bz), .kind_in(kd),
    .req_kind(rk), .req_valid(rv), .req_busy(rb));
  host_control_upper_flags uut (.clk(clk), .arst_n(arst_n), .clk_en(ce),
    .soft_reset(sr), .reg_write(wr_en), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rd),
    .link_on(lk), .owner_load(ol), .owner_value(ov), .bus_info_fetch_error(fe),
    .bus_reset(br), .req_valid(rv), .req_kind(rk), .req_busy(rb), .ack_valid(av),
    .ack_code(cd), .rom_update_allow(al), .rom_regs_update(ru), .byte_swap_on(so),
    .ack_tardy_event(ev));
  // one register write, then readback address parked at the set offset
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk) {ad, wd, wr_en} = {a, d, 1'b1};
    @(negedge clk) {ad, wr_en} = {8'h50, 1'b0};
    #1;
  endtask
  // one request through the remote node, ack looked at in its only cycle
  task automatic rq(input req_kind_t k, input logic b, v, input logic [3:0] c);
    @(negedge clk) {kd, bz, st} = {k, b, 1'b1};
    @(negedge clk) st = 0;
    @(negedge clk) `CHK(av, v)
    `CHK({cd, ev}, {c, v && c == 4'hB})
  endtask
  task automatic t_defaults;
    `CHK(rd, 32'h0080_0000)
    wr(8'h54, 32'hFFFF_FFFF);
    `CHK(rd, 32'h0080_0000)
  endtask
  task automatic t_image;
    wr(8'h50, 32'h8000_0000);
    lk = 1;
    rq(REQ_ROM_BLOCK_READ, 0, 1, 4'h1);
    wr(8'h54, 32'h8000_0000);
    br = 1;
    #1 `CHK({al, ru}, 2'b11)
    br = 0;
  endtask
  task automatic t_tardy;
    wr(8'h50, 32'h6000_0000);
    `CHK({rd, so}, {32'hE082_0000, 1'b0})
    rq(REQ_OTHER_ASYNC, 1, 1, 4'hB);
    rq(REQ_BUS_INFO, 0, 1, 4'h1);
    wr(8'h54, 32'h2000_0000);
    rq(REQ_OTHER_ASYNC, 1, 1, 4'h1);
  endtask
  task automatic t_faults;
    @(negedge clk) fe = 1;
    @(negedge clk) fe = 0;
    `CHK(al, 1'b0)
    rq(REQ_ROM_BLOCK_READ, 0, 1, 4'hE);
    lk = 0;
    rq(REQ_OTHER_ASYNC, 0, 0, 4'hE);
    wr(8'h50, 32'h8000_0000);
    @(negedge clk) sr = 1;
    @(negedge clk) sr = 0;
    `CHK({al, so}, 2'b01)
  endtask
  // frozen clock enable ignores writes; owner load clears bit 23
  task automatic t_hold;
    @(negedge clk) ce = 0;
    wr(8'h50, 32'h4000_0000);
    `CHK(so, 1'b1)
    ce = 1;
    @(negedge clk) {ol, ov} = 2'b10;
    @(negedge clk) ol = 0;
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) arst_n = 1;
    t_defaults();
    t_image();
    t_tardy();
    t_faults();
    t_hold();
    print_verdict();
  end
endmodule
`default_nettype wire
